// ==== bsc_counter.sv ====
`timescale 1ns/1ps
module bsc_counter
  import bsc_pkg::*;
#(
  parameter int unsigned OSC_DIV = BSC_OSC_DIV
)
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       count_clk,
  input  wire logic       counter_clear_input,
  input  wire logic       count_disable,
  input  wire logic       latch_hold,
  input  wire logic       ext_scan_en,
  input  wire logic       ext_scan_clk,
  output bsc_pkg::bsc_disp_t disp,
  output logic            overflow
);
  import bsc_pkg::*;

  // Divider must fit the 16-bit oscillator counter
  generate
    if (OSC_DIV < 2 || OSC_DIV > 65536)
    begin : g_bad_div
      $error("OSC_DIV must be 2 to 65536");
    end
  endgenerate

  logic         cclk_ff;
  logic         eclk_ff;
  logic         count_fall;
  logic         ext_rise;
  logic [2:0]   step;
  logic [2:0]   wrap;
  logic [3:0]   cnt     [BSC_DIGITS];
  logic [3:0]   latch_ff[BSC_DIGITS];
  logic [3:0]   shown   [BSC_DIGITS];
  logic         hold_ff;
  logic [15:0]  osc_ff;
  logic         osc_tick;
  logic         scan_tick;
  logic [1:0]   dig_ff;
  bsc_scan_st_t scan_ff;
  logic [3:0]   bcd_ff;
  logic [2:0]   sel_n_ff;
  logic         ovf_ff;

  function automatic logic [2:0] sel_of(input logic [1:0] d);
    sel_of = BSC_SEL_OFF & ~(3'h1 << d);
  endfunction

  // Edge detect on count and external scan clocks
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cclk_ff <= 1'b0;
      eclk_ff <= 1'b0;
    end
    else
    begin
      cclk_ff <= count_clk;
      eclk_ff <= ext_scan_clk;
    end
  end

  assign count_fall = cclk_ff && !count_clk && !count_disable; // RQ1 RQ11
  assign ext_rise   = !eclk_ff && ext_scan_clk;

  genvar g;
  generate
    for (g = 0; g < BSC_DIGITS; g++)
    begin : g_dec
      if (g == 0)
      begin : g_first
        assign step[g] = count_fall;
      end
      else
      begin : g_next
        assign step[g] = wrap[g-1]; // RQ15
      end
      bsc_decade u_dec (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clr      (counter_clear_input),
        .step     (step[g]),
        .digit_ff (cnt[g]),
        .wrap     (wrap[g])
      ); // RQ1

      // Capture on hold rise, keep while high
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
          latch_ff[g] <= BSC_BCD_ZERO;
        else if (latch_hold && !hold_ff)
          latch_ff[g] <= cnt[g]; // RQ2 RQ12
      end
      // Live count in the capture cycle, before the latch has loaded
      assign shown[g] = (latch_hold && hold_ff) ? latch_ff[g] : cnt[g]; // RQ12 RQ13 RQ14
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      hold_ff <= 1'b0;
    else
      hold_ff <= latch_hold;
  end

  // Overflow pulse on hundreds wrap
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ovf_ff <= 1'b0;
    else
      ovf_ff <= wrap[BSC_DIGITS-1] && !counter_clear_input; // RQ7
  end
  assign overflow = ovf_ff;

  // Internal scan oscillator, stopped in clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      osc_ff <= 16'h0000;
    else if (counter_clear_input || ext_scan_en || osc_tick)
      osc_ff <= 16'h0000; // RQ10
    else
      osc_ff <= osc_ff + 16'h0001;
  end
  assign osc_tick  = (osc_ff == 16'(OSC_DIV - 1)); // RQ5
  assign scan_tick = ext_scan_en ? ext_rise : osc_tick; // RQ6

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scan_ff <= BSC_SCAN_IDLE;
      dig_ff  <= BSC_FIRST_DIG;
    end
    else
    begin
      case (scan_ff)
        BSC_SCAN_IDLE:
        begin
          dig_ff <= BSC_FIRST_DIG; // RQ9
          if (!counter_clear_input)
            scan_ff <= BSC_SCAN_RUN;
        end
        BSC_SCAN_RUN:
        begin
          if (counter_clear_input)
          begin
            scan_ff <= BSC_SCAN_IDLE;
            dig_ff  <= BSC_FIRST_DIG; // RQ8 RQ9
          end
          else if (scan_tick)
            dig_ff <= (dig_ff == BSC_LAST_DIG) ? BSC_FIRST_DIG : dig_ff + 2'h1; // RQ5
        end
        default:
        begin
          scan_ff <= BSC_SCAN_IDLE;
          dig_ff  <= BSC_FIRST_DIG;
        end
      endcase
    end
  end

  // Registered display outputs
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bcd_ff   <= BSC_BCD_ZERO;
      sel_n_ff <= BSC_SEL_OFF;
    end
    else
    begin
      bcd_ff   <= shown[dig_ff]; // RQ3
      sel_n_ff <= counter_clear_input ? BSC_SEL_OFF : sel_of(dig_ff); // RQ4 RQ10
    end
  end
  assign disp.bcd   = bcd_ff;
  assign disp.sel_n = sel_n_ff;

  clear_counts_a: assert property (@(posedge core_clk) disable iff (!rstn)
    counter_clear_input |=> (cnt[0] == BSC_BCD_ZERO && cnt[1] == BSC_BCD_ZERO
                             && cnt[2] == BSC_BCD_ZERO)) // RQ8
    else $error("clear did not zero counters");
  clear_first_dig_a: assert property (@(posedge core_clk) disable iff (!rstn)
    counter_clear_input |=> dig_ff == BSC_FIRST_DIG) // RQ9
    else $error("scanner not at first digit in clear");
  clear_sel_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    counter_clear_input |=> disp.sel_n == BSC_SEL_OFF) // RQ10
    else $error("select active during clear");
  clear_osc_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
    counter_clear_input |=> osc_ff == 16'h0000) // RQ10
    else $error("oscillator ran during clear");
  disable_holds_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (count_disable && !counter_clear_input) |=> $stable(cnt[0])) // RQ11
    else $error("count moved while disabled");
  hold_keeps_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (latch_hold && hold_ff) |=> $stable(latch_ff[0]) && $stable(latch_ff[2])) // RQ12 RQ13
    else $error("latch changed while held");
  hold_capture_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (latch_hold && !hold_ff) |=> latch_ff[1] == $past(cnt[1])) // RQ12
    else $error("latch did not capture count");
  pass_through_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!latch_hold && dig_ff == BSC_FIRST_DIG) |=> disp.bcd == $past(cnt[0])) // RQ14
    else $error("bcd does not follow count");
  one_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $onehot0(~disp.sel_n)) // RQ4
    else $error("more than one digit selected");
  ovf_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    overflow |=> !overflow) // RQ7
    else $error("overflow longer than one cycle");
  ovf_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
    overflow |-> $past(cnt[2]) == BSC_BCD_MAX && $past(cnt[0]) == BSC_BCD_MAX) // RQ7
    else $error("overflow without 999 wrap");
  scan_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (scan_ff == BSC_SCAN_RUN && !counter_clear_input && scan_tick
     && dig_ff == BSC_LAST_DIG) |=> dig_ff == BSC_FIRST_DIG) // RQ5 RQ6
    else $error("scanner did not wrap");

  ovf_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) overflow);
  ext_scan_c: cover property (@(posedge core_clk) disable iff (!rstn)
    ext_scan_en && ext_rise);
  hold_over_clear_c: cover property (@(posedge core_clk) disable iff (!rstn)
    latch_hold && counter_clear_input);
endmodule // bsc_counter

// ==== bsc_decade.sv ====
`timescale 1ns/1ps
module bsc_decade
  import bsc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic       step,
  output logic [3:0]      digit_ff,
  output logic            wrap
);
  import bsc_pkg::*;

  assign wrap = step && (digit_ff == BSC_BCD_MAX); // RQ15

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      digit_ff <= BSC_BCD_ZERO;
    else if (clr)
      digit_ff <= BSC_BCD_ZERO; // RQ8
    else if (wrap)
      digit_ff <= BSC_BCD_ZERO; // RQ15
    else if (step)
      digit_ff <= digit_ff + 4'h1;
  end

  wrap_on_nine_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (step && !clr && digit_ff == BSC_BCD_MAX) |=> digit_ff == BSC_BCD_ZERO) // RQ15
    else $error("decade did not wrap");
  stays_bcd_a: assert property (@(posedge core_clk) disable iff (!rstn)
    digit_ff <= BSC_BCD_MAX) // RQ15
    else $error("decade left BCD range");
endmodule // bsc_decade

// ==== bsc_partner.sv ====
`timescale 1ns/1ps
module bsc_partner
(
  input  wire logic          core_clk,
  input  bsc_pkg::bsc_disp_t disp,
  input  wire logic          overflow,
  output logic               count_clk,
  output logic               ext_scan_clk
);
  import bsc_pkg::*;
  logic [3:0]  shown [3];
  int unsigned ovf_cnt;

  initial
  begin
    count_clk = 1'b0;
    ext_scan_clk = 1'b0;
    ovf_cnt = 0;
  end

  // Display keeps the digit whose select is low
  always @(posedge core_clk)
  begin
    for (int d = 0; d < 3; d++)
      if (disp.sel_n == ~(3'h1 << d)) shown[d] <= disp.bcd;
    if (overflow) ovf_cnt <= ovf_cnt + 1;
  end

  // Count pulses, each level held one cycle
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      count_clk <= 1'b1;
      @(posedge core_clk);
      count_clk <= 1'b0;
    end
  endtask

  // External scan clock, only while asked for
  task automatic ext_scan(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge core_clk);
      ext_scan_clk <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext_scan_clk <= 1'b0;
    end
  endtask
endmodule // bsc_partner

// ==== bsc_pkg.sv ====
// Contract
// RQ1: Three BCD decades count on the falling edge of the count clock, chained synchronously.
// RQ2: Each decade feeds its own four-bit holding latch.
// RQ3: The latched digits share one active-high four-bit BCD output, one digit at a time.
// RQ4: One active-low select per digit is asserted for the digit currently on the BCD output.
// RQ5: The digit scanner steps on a scan clock from an internal oscillator.
// RQ6: An external scan clock may override the internal oscillator and the scanner then uses it.
// RQ7: The overflow output gives exactly one pulse per 1000 input counts.
// RQ8: Master reset high clears all decades and initializes the scanner.
// RQ9: While master reset is high the scanner points at the first digit.
// RQ10: While master reset is high all selects are inactive and the scan oscillator is stopped.
// RQ11: Count disable high blocks count edges and keeps the count.
// RQ12: Latch hold rising captures the counters, and the latches hold while it stays high.
// RQ13: Latch hold kept high through a reset preserves the latched value across it.
// RQ14: While latch hold is low the latches pass the running count through.
// RQ15: Each decade counts 0 to 9 and wraps, its wrap advancing the next decade on the same edge.
package bsc_pkg;
  localparam int unsigned BSC_DIGITS    = 3;
  localparam logic [3:0]  BSC_BCD_ZERO  = 4'h0;
  localparam logic [3:0]  BSC_BCD_MAX   = 4'h9;
  localparam logic [1:0]  BSC_FIRST_DIG = 2'h0;
  localparam logic [1:0]  BSC_LAST_DIG  = 2'h2;
  localparam logic [2:0]  BSC_SEL_OFF   = 3'h7;
  localparam int unsigned BSC_OSC_DIV   = 200;

  typedef struct packed {
    logic [3:0] bcd;
    logic [2:0] sel_n;
  } bsc_disp_t;

  typedef enum logic [1:0] {
    BSC_SCAN_IDLE = 2'b00,
    BSC_SCAN_RUN  = 2'b01
  } bsc_scan_st_t;
endpackage

// ==== tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) \
  begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %0h vs %0h", $time, a, b); end end
module tb_top;
  import bsc_pkg::*;
  logic          core_clk;
  logic          rstn;
  logic          clr;
  logic          dis;
  logic          hold;
  logic          ext_en;
  logic          count_clk;
  logic          ext_scan_clk;
  logic          overflow;
  bsc_disp_t     disp;
  int            checks = 0;
  int            miscompares = 0;
  int            cycles = 0;
  int unsigned   ovf0;
  logic [2:0]    sel0;

  always #25 core_clk = ~core_clk;

  bsc_counter #(.OSC_DIV(4)) bsc_counter_i
  (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .count_clk           (count_clk),
    .counter_clear_input (clr),
    .count_disable       (dis),
    .latch_hold          (hold),
    .ext_scan_en         (ext_en),
    .ext_scan_clk        (ext_scan_clk),
    .disp                (disp),
    .overflow            (overflow)
  );

  bsc_partner bsc_partner_i
  (
    .core_clk     (core_clk),
    .disp         (disp),
    .overflow     (overflow),
    .count_clk    (count_clk),
    .ext_scan_clk (ext_scan_clk)
  );

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      miscompares++;
      test_done();
    end
  end

  // Compare the three displayed digits, hundreds first
  task automatic scan_chk(input logic [11:0] v);
    repeat (40) @(posedge core_clk);
    `CHK(bsc_partner_i.shown[2], v[11:8])
    `CHK(bsc_partner_i.shown[1], v[7:4])
    `CHK(bsc_partner_i.shown[0], v[3:0])
  endtask

  task automatic t_count;
    bsc_partner_i.pulse(123);
    scan_chk(12'h123);
  endtask

  task automatic t_disable;
    @(posedge core_clk) dis <= 1'b1;
    bsc_partner_i.pulse(5);
    @(posedge core_clk) dis <= 1'b0;
    scan_chk(12'h123);
  endtask

  task automatic t_latch_clear;
    int n;
    @(posedge core_clk) hold <= 1'b1;
    bsc_partner_i.pulse(7);
    scan_chk(12'h123);
    @(posedge core_clk) clr <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK(disp.sel_n, BSC_SEL_OFF)
    @(posedge core_clk) clr <= 1'b0;
    n = 0;
    while (disp.sel_n === BSC_SEL_OFF && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK(disp.sel_n, 3'h6)
    scan_chk(12'h123);
    @(posedge core_clk) hold <= 1'b0;
    scan_chk(12'h000);
  endtask

  task automatic t_overflow;
    ovf0 = bsc_partner_i.ovf_cnt;
    bsc_partner_i.pulse(999);
    repeat (4) @(posedge core_clk);
    `CHK(bsc_partner_i.ovf_cnt, ovf0)
    bsc_partner_i.pulse(1);
    repeat (4) @(posedge core_clk);
    `CHK(bsc_partner_i.ovf_cnt, ovf0 + 1)
    scan_chk(12'h000);
  endtask

  task automatic t_ext_scan;
    bsc_partner_i.pulse(45);
    @(posedge core_clk) ext_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    sel0 = disp.sel_n;
    repeat (20) @(posedge core_clk);
    `CHK(disp.sel_n, sel0)
    bsc_partner_i.ext_scan(6);
    scan_chk(12'h045);
  endtask

  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    clr = 1'b0;
    dis = 1'b0;
    hold = 1'b0;
    ext_en = 1'b0;
    repeat (12) @(posedge core_clk);
    `CHK(disp.sel_n, BSC_SEL_OFF)
    `CHK(disp.bcd, BSC_BCD_ZERO)
    rstn <= 1'b1;
    t_count();
    t_disable();
    t_latch_clear();
    t_overflow();
    t_ext_scan();
    test_done();
  end
endmodule // tb_top
